// ===== pkg/csbi_params.svh
// constants for the cpu system bus interface
`ifndef CSBI_PARAMS_SVH
`define CSBI_PARAMS_SVH
`define CSBI_CYCLE_CLKS 4'h8
`define CSBI_TPA_PH 3'h1
`define CSBI_TPB_PH 3'h6
`define CSBI_ADDR_LO_PH 3'h3
`define CSBI_WR_FROM_PH 3'h4
`define CSBI_WR_TO_PH 3'h5
`define CSBI_RD_FROM_PH 3'h2
`define CSBI_XDES_INT 4'h2
`define CSBI_PDES_INT 4'h1
`define CSBI_SC_FETCH 2'h0
`define CSBI_SC_EXEC 2'h1
`define CSBI_SC_DMA 2'h2
`define CSBI_SC_INT 2'h3
`endif

// ===== pkg/csbi_pkg.sv
// types for the cpu system bus interface
package csbi_pkg;
   typedef enum logic [3:0] {
      CSBI_FETCH = 4'b0001,
      CSBI_EXEC = 4'b0010,
      CSBI_DMA = 4'b0100,
      CSBI_INT = 4'b1000
   } csbi_state_t;
   typedef enum logic [1:0] {
      CSBI_OP_MEM_RD = 2'h0,
      CSBI_OP_MEM_WR = 2'h1,
      CSBI_OP_IO = 2'h2,
      CSBI_OP_NONE = 2'h3
   } csbi_op_t;
endpackage

// ===== pkg/csbi_bus_if.sv
// backplane bus between processor end and far end
`timescale 1ns/1ps
interface csbi_bus_if;
   logic [7:0] addr;
   logic [7:0] data_cpu;
   logic data_cpu_oe;
   logic [7:0] data_ext;
   logic data_ext_oe;
   logic [2:0] io_select_lines;
   logic memory_read_strobe;
   logic memory_write_strobe;
   logic early_timing_pulse;
   logic late_timing_pulse;
   logic [1:0] state_code_lines;
   logic [3:0] external_flag_inputs;
   logic int_req;
   logic dma_input_request;
   logic dma_output_request;
   modport cpu (
      output addr, data_cpu, data_cpu_oe, io_select_lines, memory_read_strobe,
      output memory_write_strobe, early_timing_pulse, late_timing_pulse, state_code_lines,
      input data_ext, data_ext_oe, external_flag_inputs, int_req, dma_input_request, dma_output_request
   );
   modport ext (
      input addr, data_cpu, data_cpu_oe, io_select_lines, memory_read_strobe,
      input memory_write_strobe, early_timing_pulse, late_timing_pulse, state_code_lines,
      output data_ext, data_ext_oe, external_flag_inputs, int_req, dma_input_request, dma_output_request
   );
endinterface

// ===== rtl/csbi_sync.sv
// two flip-flop synchroniser, one per bit
`timescale 1ns/1ps
module csbi_sync #(
   parameter int WIDTH = 1
) (
   // clock and reset
   input wire logic mclk_i,
   input wire logic rstn_i,
   // data
   input wire logic [WIDTH-1:0] d_i,
   output logic [WIDTH-1:0] q_o
);
   logic [WIDTH-1:0] meta_q;
   initial begin
      if (WIDTH < 1) $error("csbi_sync width must be positive");
   end
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         meta_q <= '0;
         q_o <= '0;
      end else begin
         meta_q <= d_i;
         q_o <= meta_q;
      end
   end
endmodule // csbi_sync

// ===== rtl/csbi_cpu_end.sv
// processor end of the system bus: cycle sequencer, strobes, interrupt and dma entry
//
// The address map and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
`include "csbi_params.svh"
module csbi_cpu_end (
   // clock and reset
   input wire logic mclk_i,
   input wire logic rstn_i,
   // backplane
   csbi_bus_if.cpu bus,
   // instruction request from core logic
   input wire logic op_valid_i,
   input wire csbi_pkg::csbi_op_t op_kind_i,
   input wire logic [15:0] op_addr_i,
   input wire logic [7:0] op_wdata_i,
   input wire logic [3:0] op_io_code_i,
   input wire logic ie_set_i,
   output logic op_ready_o,
   // status to core logic
   output logic [7:0] rdata_o,
   output logic rdata_valid_o,
   output logic [3:0] flags_o,
   output logic [15:0] pc_o,
   output logic [15:0] dma_ptr_o,
   output logic [7:0] saved_des_o,
   output logic ie_o,
   output csbi_pkg::csbi_state_t state_o
);
   import csbi_pkg::*;
   // ************
   // state
   // ************
   csbi_state_t state_q;
   logic [2:0] ph_q;
   logic [15:0] regs_q [16];
   logic [3:0] xdes_q, pdes_q;
   logic [7:0] tdes_q;
   logic ie_q;
   csbi_op_t op_q;
   logic [15:0] maddr_q;
   logic [7:0] wdata_q;
   logic [2:0] io_q;
   logic io_dir_q;
   logic [7:0] rdata_q;
   logic rdv_q;
   logic [3:0] flags_s;
   logic int_s, dma_input_request_s, dma_output_request_s;
   logic last_ph;
   logic dma_pend, int_pend;
   logic dma_out_q;
   csbi_sync #(.WIDTH(7)) u_sync (
      .mclk_i(mclk_i),
      .rstn_i(rstn_i),
      .d_i({bus.external_flag_inputs, bus.int_req, bus.dma_input_request, bus.dma_output_request}),
      .q_o({flags_s, int_s, dma_input_request_s, dma_output_request_s})
   );
   assign last_ph = (ph_q == 3'((`CSBI_CYCLE_CLKS) - 4'h1));
   assign dma_pend = dma_input_request_s | dma_output_request_s;
   assign int_pend = int_s & ie_q;
   assign flags_o = flags_s;
   assign pc_o = regs_q[pdes_q];
   assign dma_ptr_o = regs_q[0];
   assign saved_des_o = tdes_q;
   assign ie_o = ie_q;
   assign state_o = state_q;
   assign rdata_o = rdata_q;
   assign rdata_valid_o = rdv_q;
   // core request taken at the end of a fetch cycle, executed in the next cycle
   assign op_ready_o = (state_q == CSBI_FETCH) & last_ph;
   // ************
   // machine cycle phase
   // ************
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ph_q <= 3'h0;
      end else begin
         ph_q <= ph_q + 3'h1;
      end
   end
   // ************
   // cycle sequencing
   // ************
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         state_q <= CSBI_FETCH;
      end else if (last_ph) begin
         case (state_q)
            CSBI_FETCH: begin
               // a fetched instruction always runs before any stolen cycle
               state_q <= CSBI_EXEC;
            end
            CSBI_EXEC, CSBI_DMA, CSBI_INT: begin
               // interrupt waits for instruction end; dma steals any cycle boundary except the one after a fetch
               if (dma_pend) state_q <= CSBI_DMA;
               else if (int_pend && state_q != CSBI_INT) state_q <= CSBI_INT;
               else state_q <= CSBI_FETCH;
            end
            default: state_q <= CSBI_FETCH;
         endcase
      end
   end
   // ************
   // dma direction, fixed for the whole stolen cycle
   // ************
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         dma_out_q <= 1'b0;
      end else if (last_ph) begin
         dma_out_q <= dma_output_request_s;
      end
   end
   // ************
   // registers, designators, interrupt enable
   // ************
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         for (int i = 0; i < 16; i++) regs_q[i] <= 16'h0000;
         xdes_q <= 4'h0;
         pdes_q <= 4'h0;
         tdes_q <= 8'h00;
         ie_q <= 1'b1;
      end else begin
         if (state_q == CSBI_FETCH && last_ph) regs_q[pdes_q] <= regs_q[pdes_q] + 16'h0001;
         if (state_q == CSBI_DMA && last_ph) regs_q[0] <= regs_q[0] + 16'h0001;
         if (state_q == CSBI_INT && ph_q == 3'h0) begin
            tdes_q <= {xdes_q, pdes_q};
            xdes_q <= `CSBI_XDES_INT;
            pdes_q <= `CSBI_PDES_INT;
            ie_q <= 1'b0;
         end else if (ie_set_i) begin
            ie_q <= 1'b1;
         end
      end
   end
   // ************
   // operation capture
   // ************
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         op_q <= CSBI_OP_NONE;
         maddr_q <= 16'h0000;
         wdata_q <= 8'h00;
         io_q <= 3'h0;
         io_dir_q <= 1'b0;
      end else if (op_ready_o) begin
         op_q <= op_valid_i ? op_kind_i : CSBI_OP_NONE;
         maddr_q <= op_addr_i;
         wdata_q <= op_wdata_i;
         io_q <= op_io_code_i[2:0];
         io_dir_q <= op_io_code_i[3];
      end
   end
   // ************
   // bus outputs
   // ************
   logic [15:0] cyc_addr;
   logic is_exec, is_io, is_rd, is_wr;
   always_comb begin
      case (state_q)
         CSBI_FETCH: cyc_addr = regs_q[pdes_q];
         CSBI_DMA: cyc_addr = regs_q[0];
         CSBI_EXEC: cyc_addr = maddr_q;
         default: cyc_addr = regs_q[pdes_q];
      endcase
   end
   assign is_exec = (state_q == CSBI_EXEC);
   assign is_io = is_exec & (op_q == CSBI_OP_IO);
   // fetch, memory read and dma output read memory; in io cycles the read strobe follows io_dir_q instead
   assign is_rd = (state_q == CSBI_FETCH) | (is_exec & (op_q == CSBI_OP_MEM_RD)) | (is_io & ~io_dir_q) |
                  ((state_q == CSBI_DMA) & dma_out_q);
   // memory write, io input written to memory, dma input
   assign is_wr = (is_exec & (op_q == CSBI_OP_MEM_WR)) | (is_io & io_dir_q) | ((state_q == CSBI_DMA) & ~dma_out_q);
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         bus.addr <= 8'h00;
         bus.io_select_lines <= 3'h0;
         bus.memory_read_strobe <= 1'b0;
         bus.memory_write_strobe <= 1'b0;
         bus.early_timing_pulse <= 1'b0;
         bus.late_timing_pulse <= 1'b0;
         bus.state_code_lines <= `CSBI_SC_FETCH;
         bus.data_cpu <= 8'h00;
         bus.data_cpu_oe <= 1'b0;
      end else begin
         bus.addr <= (ph_q >= `CSBI_ADDR_LO_PH) ? cyc_addr[7:0] : cyc_addr[15:8];
         bus.io_select_lines <= is_io ? io_q : 3'h0;
         if (is_io) bus.memory_read_strobe <= io_dir_q;
         else bus.memory_read_strobe <= is_rd & (ph_q >= `CSBI_RD_FROM_PH);
         bus.memory_write_strobe <= is_wr & (ph_q >= `CSBI_WR_FROM_PH) & (ph_q <= `CSBI_WR_TO_PH);
         bus.early_timing_pulse <= (ph_q == `CSBI_TPA_PH);
         bus.late_timing_pulse <= (ph_q == `CSBI_TPB_PH);
         case (state_q)
            CSBI_FETCH: bus.state_code_lines <= `CSBI_SC_FETCH;
            CSBI_EXEC: bus.state_code_lines <= `CSBI_SC_EXEC;
            CSBI_DMA: bus.state_code_lines <= `CSBI_SC_DMA;
            CSBI_INT: bus.state_code_lines <= `CSBI_SC_INT;
            default: bus.state_code_lines <= `CSBI_SC_FETCH;
         endcase
         // memory write or io output: drive data through the late pulse end
         bus.data_cpu <= wdata_q;
         bus.data_cpu_oe <= is_exec & (op_q == CSBI_OP_MEM_WR | (is_io & ~io_dir_q));
      end
   end
   // ************
   // read data capture
   // ************
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rdata_q <= 8'h00;
         rdv_q <= 1'b0;
      end else begin
         rdv_q <= 1'b0;
         if (is_exec && op_q == CSBI_OP_MEM_RD && ph_q == `CSBI_TPB_PH && bus.data_ext_oe) begin
            rdata_q <= bus.data_ext;
            rdv_q <= 1'b1;
         end
      end
   end
endmodule // csbi_cpu_end

// ===== rtl/csbi_ext_end.sv
// far end of the system bus: memory with address latch, output port, flag and request drivers
`timescale 1ns/1ps
`include "csbi_params.svh"
module csbi_ext_end #(
   parameter int DEPTH = 256
) (
   // clock and reset
   input wire logic mclk_i,
   input wire logic rstn_i,
   // backplane
   csbi_bus_if.ext bus,
   // user side
   input wire logic [3:0] flags_i,
   input wire logic int_req_i,
   input wire logic dma_in_i,
   input wire logic dma_out_i,
   input wire logic [7:0] port_in_i,
   output logic [7:0] port_out_o,
   output logic [15:0] last_addr_o
);
   import csbi_pkg::*;
   localparam int AW = $clog2(DEPTH);
   initial begin
      if (DEPTH < 2 || DEPTH > 65536) $error("csbi_ext_end depth out of range");
   end
   logic [7:0] mem_q [DEPTH];
   logic [7:0] hi_q;
   logic tpa_d, tpb_d, wr_d;
   logic [15:0] full_addr;
   assign full_addr = {hi_q, bus.addr};
   assign bus.external_flag_inputs = flags_i;
   assign bus.int_req = int_req_i;
   // requests reach the processor raw and are resynchronised there
   assign bus.dma_input_request = dma_in_i;
   assign bus.dma_output_request = dma_out_i;
   // drive only while read strobe is high
   assign bus.data_ext_oe = bus.memory_read_strobe;
   assign bus.data_ext = (bus.io_select_lines != 3'h0) ? port_in_i : mem_q[full_addr[AW-1:0]];
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         tpa_d <= 1'b0;
         tpb_d <= 1'b0;
         wr_d <= 1'b0;
         hi_q <= 8'h00;
         port_out_o <= 8'h00;
         last_addr_o <= 16'h0000;
      end else begin
         tpa_d <= bus.early_timing_pulse;
         tpb_d <= bus.late_timing_pulse;
         wr_d <= bus.memory_write_strobe;
         if (tpa_d && !bus.early_timing_pulse) hi_q <= bus.addr;
         if (tpb_d && !bus.late_timing_pulse && bus.io_select_lines != 3'h0 && bus.data_cpu_oe)
            port_out_o <= bus.data_cpu;
         if (wr_d && !bus.memory_write_strobe) last_addr_o <= full_addr;
      end
   end
   // memory write at trailing edge of the write strobe
   always_ff @(posedge mclk_i) begin
      if (wr_d && !bus.memory_write_strobe)
         mem_q[full_addr[AW-1:0]] <= bus.data_cpu_oe ? bus.data_cpu : port_in_i;
   end
endmodule // csbi_ext_end

// ===== testbench/csbi_bus_assertions.sv
// checker on the backplane signals
`timescale 1ns/1ps
module csbi_bus_assertions (
   // clock and reset
   input wire logic mclk_i,
   input wire logic rstn_i,
   // backplane
   input wire logic [7:0] addr,
   input wire logic [7:0] data_cpu,
   input wire logic data_cpu_oe,
   input wire logic data_ext_oe,
   input wire logic [2:0] io_select_lines,
   input wire logic memory_read_strobe,
   input wire logic memory_write_strobe,
   input wire logic early_timing_pulse,
   input wire logic late_timing_pulse,
   input wire logic [1:0] state_code_lines
);
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rstn_i);
   AST_IO_IDLE: assert property (state_code_lines != 2'h1 |-> io_select_lines == 3'h0)
      else $error("io select active outside execute");
   AST_EARLY_ONCE: assert property (early_timing_pulse |=> !early_timing_pulse [*7] ##1 early_timing_pulse)
      else $error("early pulse not once per cycle");
   AST_LATE_AFTER: assert property (early_timing_pulse |-> ##5 late_timing_pulse)
      else $error("late pulse missing after early pulse");
   AST_WR_ADDR: assert property (memory_write_strobe |-> $stable(addr))
      else $error("address moved under write strobe");
   AST_WR_LEN: assert property ($rose(memory_write_strobe) |=> memory_write_strobe ##1 !memory_write_strobe)
      else $error("write strobe length wrong");
   AST_DATA_HOLD: assert property (late_timing_pulse && data_cpu_oe |-> $stable(data_cpu))
      else $error("data moved at late pulse");
   AST_EXT_DRIVE: assert property (data_ext_oe && state_code_lines != 2'h2 |-> memory_read_strobe)
      else $error("far end drives without read strobe");
   AST_NO_FIGHT: assert property (!(data_cpu_oe && data_ext_oe))
      else $error("both ends drive the data bus");
   AST_IO_DIR: assert property (io_select_lines != 3'h0 && data_cpu_oe |-> !memory_read_strobe)
      else $error("read strobe high during io output");
   AST_INT_LEN: assert property ($changed(state_code_lines) && state_code_lines == 2'h3 |->
      (state_code_lines == 2'h3) [*8] ##1 state_code_lines != 2'h3)
      else $error("interrupt cycle length wrong");
   AST_DMA_LEN: assert property ($changed(state_code_lines) && state_code_lines == 2'h2 |->
      (state_code_lines == 2'h2) [*8])
      else $error("dma cycle too short");
endmodule // csbi_bus_assertions

// ===== testbench/tb_top.sv
// self-checking testbench of both bus ends
`timescale 1ns/1ps
module tb_top;
   import csbi_pkg::*;
   // ***
   // stimulus and observation
   // ***
   logic mclk_i = 1'b0;
   logic rstn_i = 1'b0;
   logic op_valid_i = 1'b0;
   csbi_op_t op_kind_i = CSBI_OP_NONE;
   logic [15:0] op_addr_i = 16'h0000;
   logic [7:0] op_wdata_i = 8'h00;
   logic [3:0] op_io_code_i = 4'h0;
   logic ie_set_i = 1'b0;
   logic [3:0] flags_i = 4'h0;
   logic int_req_i = 1'b0;
   logic dma_in_i = 1'b0;
   logic dma_out_i = 1'b0;
   logic [7:0] port_in_i = 8'h00;
   logic op_ready_o, rdata_valid_o, ie_o;
   logic [7:0] rdata_o, saved_des_o, port_out_o;
   logic [7:0] rd_seen = 8'h00;
   logic [3:0] flags_o;
   logic [15:0] pc_o, dma_ptr_o, last_addr_o;
   csbi_state_t state_o;
   int num_errors = 0;
   int checked = 0;
   int int_clks = 0;
   int dma_clks = 0;
   csbi_bus_if bus ();
   csbi_cpu_end u_csbi_cpu_end (.mclk_i(mclk_i), .rstn_i(rstn_i), .bus(bus), .op_valid_i(op_valid_i),
      .op_kind_i(op_kind_i), .op_addr_i(op_addr_i), .op_wdata_i(op_wdata_i), .op_io_code_i(op_io_code_i),
      .ie_set_i(ie_set_i), .op_ready_o(op_ready_o), .rdata_o(rdata_o), .rdata_valid_o(rdata_valid_o),
      .flags_o(flags_o), .pc_o(pc_o), .dma_ptr_o(dma_ptr_o), .saved_des_o(saved_des_o), .ie_o(ie_o),
      .state_o(state_o));
   csbi_ext_end #(.DEPTH(256)) u_csbi_ext_end (.mclk_i(mclk_i), .rstn_i(rstn_i), .bus(bus), .flags_i(flags_i),
      .int_req_i(int_req_i), .dma_in_i(dma_in_i), .dma_out_i(dma_out_i), .port_in_i(port_in_i),
      .port_out_o(port_out_o), .last_addr_o(last_addr_o));
   csbi_bus_assertions u_csbi_bus_assertions (.mclk_i(mclk_i), .rstn_i(rstn_i), .addr(bus.addr),
      .data_cpu(bus.data_cpu), .data_cpu_oe(bus.data_cpu_oe), .data_ext_oe(bus.data_ext_oe),
      .io_select_lines(bus.io_select_lines), .memory_read_strobe(bus.memory_read_strobe),
      .memory_write_strobe(bus.memory_write_strobe), .early_timing_pulse(bus.early_timing_pulse),
      .late_timing_pulse(bus.late_timing_pulse), .state_code_lines(bus.state_code_lines));
   initial begin
      forever #4 mclk_i = ~mclk_i;
   end
   always @(posedge mclk_i) begin
      if (state_o === CSBI_INT) int_clks <= int_clks + 1;
      if (state_o === CSBI_DMA) dma_clks <= dma_clks + 1;
      if (rdata_valid_o === 1'b1) rd_seen <= rdata_o;
   end
   task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic finish_test();
      if (num_errors == 0 && checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic wait_for(input int sel, input string name);
      int i;
      logic hit;
      i = 0;
      do begin
         @(negedge mclk_i);
         i++;
         case (sel)
            0: hit = op_ready_o;
            1: hit = bus.late_timing_pulse;
            2: hit = bus.early_timing_pulse;
            3: hit = (state_o == CSBI_INT);
            4: hit = (state_o != CSBI_INT);
            default: hit = (state_o == CSBI_DMA);
         endcase
      end while (hit !== 1'b1 && i < 64);
      if (hit !== 1'b1) begin
         chk(name, 16'h0000, 16'h0001);
         finish_test();
      end
   endtask
   // ***
   // scenarios
   // ***
   task automatic do_op(input csbi_op_t k, input logic [15:0] a, input logic [7:0] w, input logic [3:0] c);
      @(posedge mclk_i);
      op_valid_i <= 1'b1;
      op_kind_i <= k;
      op_addr_i <= a;
      op_wdata_i <= w;
      op_io_code_i <= c;
      wait_for(0, "op_ready_o");
      chk("io_select_lines", bus.io_select_lines, 16'h0000);
      @(posedge mclk_i);
      op_valid_i <= 1'b0;
      wait_for(1, "late_timing_pulse");
   endtask
   task automatic t_flags();
      flags_i <= 4'ha;
      repeat (8) @(negedge mclk_i);
      chk("flags_o", flags_o, 16'h000a);
      @(posedge mclk_i);
      flags_i <= 4'h5;
      repeat (8) @(negedge mclk_i);
      chk("flags_o", flags_o, 16'h0005);
   endtask
   task automatic t_mem();
      do_op(CSBI_OP_MEM_WR, 16'h1234, 8'h5a, 4'h0);
      repeat (2) @(negedge mclk_i);
      chk("last_addr_o", last_addr_o, 16'h1234);
      do_op(CSBI_OP_MEM_WR, 16'h5678, 8'ha5, 4'h0);
      repeat (2) @(negedge mclk_i);
      chk("last_addr_o", last_addr_o, 16'h5678);
      do_op(CSBI_OP_MEM_RD, 16'h1234, 8'h00, 4'h0);
      repeat (3) @(negedge mclk_i);
      chk("rdata_o", rd_seen, 16'h005a);
   endtask
   task automatic t_io();
      @(posedge mclk_i);
      port_in_i <= 8'hc3;
      do_op(CSBI_OP_IO, 16'h1234, 8'h5a, 4'h2);
      chk("io_select_lines", bus.io_select_lines, 16'h0002);
      chk("memory_read_strobe", bus.memory_read_strobe, 16'h0000);
      repeat (2) @(negedge mclk_i);
      chk("port_out_o", port_out_o, 16'h005a);
      do_op(CSBI_OP_IO, 16'h0020, 8'h00, 4'hd);
      chk("io_select_lines", bus.io_select_lines, 16'h0005);
      chk("memory_read_strobe", bus.memory_read_strobe, 16'h0001);
      do_op(CSBI_OP_MEM_RD, 16'h0020, 8'h00, 4'h0);
      repeat (3) @(negedge mclk_i);
      chk("rdata_o", rd_seen, 16'h00c3);
   endtask
   task automatic t_dma();
      logic [15:0] base;
      base = dma_ptr_o;
      @(posedge mclk_i);
      dma_in_i <= 1'b1;
      wait_for(5, "dma state");
      wait_for(2, "early_timing_pulse");
      @(posedge mclk_i);
      dma_in_i <= 1'b0;
      repeat (40) @(negedge mclk_i);
      chk("dma_clks", dma_clks, 16'h0008);
      chk("dma_ptr_o", dma_ptr_o, base + 16'h0001);
      @(posedge mclk_i);
      dma_out_i <= 1'b1;
      repeat (40) @(negedge mclk_i);
      @(posedge mclk_i);
      dma_out_i <= 1'b0;
      repeat (40) @(negedge mclk_i);
      chk("dma_clks", dma_clks % 8, 16'h0000);
      chk("dma back to back", dma_clks >= 32, 16'h0001);
      chk("dma_ptr_o", dma_ptr_o, base + 16'(dma_clks / 8));
   endtask
   task automatic t_int();
      @(posedge mclk_i);
      int_req_i <= 1'b1;
      wait_for(3, "interrupt state");
      wait_for(4, "interrupt end");
      chk("int_clks", int_clks, 16'h0008);
      chk("pc_o", pc_o, 16'h0000);
      chk("ie_o", ie_o, 16'h0000);
      chk("saved_des_o", saved_des_o, 16'h0000);
      repeat (40) @(negedge mclk_i);
      chk("int_clks", int_clks, 16'h0008);
      @(posedge mclk_i);
      ie_set_i <= 1'b1;
      @(posedge mclk_i);
      ie_set_i <= 1'b0;
      wait_for(3, "interrupt state");
      wait_for(4, "interrupt end");
      chk("int_clks", int_clks, 16'h0010);
      chk("saved_des_o", saved_des_o, 16'h0021);
      @(posedge mclk_i);
      int_req_i <= 1'b0;
   endtask
   initial begin
      repeat (10) @(posedge mclk_i);
      rstn_i <= 1'b1;
      t_flags();
      t_mem();
      t_io();
      t_int();
      t_dma();
      finish_test();
   end
endmodule // tb_top
